// ===== mcp_axis_store.sv
// per-axis argument store with registered read port
`timescale 1ns/1ps
module mcp_axis_store
  import mcp_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // write port
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_addr,
  input  wire logic [31:0] wr_data,
  // read port
  input  wire logic        rd_en,
  input  wire logic [2:0]  rd_addr,
  output logic             rd_valid,
  output logic      [2:0]  rd_axis,
  output logic      [31:0] rd_data
);
  logic [31:0] mem_reg [NUM_AXES];
  logic        rd_valid_reg, rd_valid_next;
  logic [2:0]  rd_axis_reg, rd_axis_next;
  logic [31:0] rd_data_reg, rd_data_next;

  always_comb begin
    rd_valid_next = rd_en;
    rd_axis_next  = rd_en ? rd_addr : rd_axis_reg;
    rd_data_next  = rd_en ? mem_reg[rd_addr] : rd_data_reg;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid_reg <= 1'b0;
      rd_axis_reg  <= 3'd0;
      rd_data_reg  <= 32'h0;
    end else begin
      rd_valid_reg <= rd_valid_next;
      rd_axis_reg  <= rd_axis_next;
      rd_data_reg  <= rd_data_next;
    end
  end

  generate
    for (genvar g = 0; g < NUM_AXES; g++) begin : g_word
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          mem_reg[g] <= 32'h0;
        end else if (wr_en && wr_addr == 3'(g)) begin
          mem_reg[g] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_valid = rd_valid_reg;
  assign rd_axis  = rd_axis_reg;
  assign rd_data  = rd_data_reg;
endmodule : mcp_axis_store

// ===== mcp_host_model.sv
// host side model: feeds command bytes to the parser one per cycle
`timescale 1ns/1ps
module mcp_host_model (
  // clock
  input  wire logic       mclk,
  // byte stream
  output logic            rx_valid,
  output logic      [7:0] rx_data
);
  logic [7:0] byte_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  // bytes leave in order; idle data toggles so stale bytes never look valid
  always @(negedge mclk) begin
    if (byte_q.size() != 0) begin
      rx_valid <= 1'b1;
      rx_data  <= byte_q.pop_front();
    end else begin
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
    end
  end
  task automatic text(input string s);
    for (int i = 0; i < s.len(); i++) byte_q.push_back(s[i]);
  endtask : text
  task automatic put(input logic [7:0] b[$]);
    foreach (b[i]) byte_q.push_back(b[i]);
  endtask : put
endmodule : mcp_host_model

// ===== mcp_parser.sv
// text and binary command parser front end
// Overview of operation
// RL1 - text command is two upper-case letters, optional space, then arguments
// RL2 - semicolon or carriage return ends a text command and releases it
// RL3 - comma-separated per-axis arguments; empty position keeps stored value
// RL4 - question mark in an axis position reports that axis's stored value
// RL5 - axis letter, equals sign and value assigns that axis only
// RL6 - action axis letters A to H without commas; none means all axes
// RL7 - letters S and T select coordinated planes, mixable with axes
// RL8 - binary command code lies in range 80 to FF
// RL9 - binary commands only accepted directly from host, not from programs
// RL10 - binary header is code, size, plane, axis mask, then fields
// RL11 - size byte: 00 none, 01, 02, 04 bytes, 06 real
// RL12 - real field is four integer bytes then two fraction bytes
// RL13 - plane byte 00 means no plane, 01 means plane S
// RL14 - mask bit 0 is axis A up to bit 7 axis H
// RL15 - one field per set bit, ascending, big-endian two's complement
// RL16 - binary codes map by fixed table; reserved codes have no command
// RL17 - reply colon for a valid command, question mark for invalid
// RL18 - reserved code or undefined size byte is rejected as invalid
`timescale 1ns/1ps
module mcp_parser
  import mcp_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // incoming command bytes
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_from_program,
  // reply character
  output logic             resp_valid,
  output logic      [7:0]  resp_data,
  // decoded command
  output logic             cmd_valid,
  output logic             cmd_binary,
  output logic      [15:0] cmd_code,
  output logic      [7:0]  cmd_axis_mask,
  output logic             cmd_plane_s,
  output logic             cmd_plane_t,
  // per-axis argument
  output logic             arg_valid,
  output logic      [2:0]  arg_axis,
  output logic      [31:0] arg_value,
  output logic      [15:0] arg_frac,
  // query report
  output logic             rpt_valid,
  output logic      [2:0]  rpt_axis,
  output logic      [31:0] rpt_value
);
  mcp_state_type state_reg, state_next;
  logic [7:0]  c1_reg, c1_next, code_reg, code_next;
  logic [31:0] acc_reg, acc_next;
  logic        neg_reg, neg_next, num_reg, num_next, qry_reg, qry_next;
  logic        fld_reg, fld_next, eq_reg, eq_next, err_reg, err_next, bprog_reg, bprog_next;
  logic [2:0]  idx_reg, idx_next, fcnt_reg, fcnt_next;
  logic [7:0]  lmask_reg, lmask_next, bsize_reg, bsize_next, bplane_reg, bplane_next;
  logic [7:0]  bmask_reg, bmask_next, bpend_reg, bpend_next;
  logic [1:0]  lplane_reg, lplane_next, lcnt_reg, lcnt_next, hcnt_reg, hcnt_next;
  logic [47:0] facc_reg, facc_next;
  logic        resp_valid_reg, resp_valid_next, cmd_valid_reg, cmd_valid_next;
  logic        cmd_binary_reg, cmd_binary_next, plane_s_reg, plane_s_next, plane_t_reg, plane_t_next;
  logic [7:0]  resp_data_reg, resp_data_next, cmask_reg, cmask_next;
  logic [15:0] cmd_code_reg, cmd_code_next, arg_frac_reg, arg_frac_next;
  logic        arg_valid_reg, arg_valid_next;
  logic [2:0]  arg_axis_reg, arg_axis_next;
  logic [31:0] arg_value_reg, arg_value_next;
  logic        rd_en;
  logic [2:0]  rd_addr;

  always_comb begin
    logic [7:0] b, dsub, bmk;
    logic [2:0] ax;
    logic       fin, term, bend, isterm, upper, digit, axl, bad;
    b = rx_data; dsub = rx_data - CH_0; bmk = bmask_reg; ax = mcp_lowest_bit(bpend_reg);
    fin = 1'b0; term = 1'b0; bend = 1'b0; bad = 1'b0;
    isterm = (b == CH_SEMI) || (b == CH_CR); // RL2
    upper  = (b >= CH_A) && (b <= CH_Z);
    digit  = (b >= CH_0) && (b <= CH_9);
    axl    = (b >= CH_A) && (b <= CH_H);
    state_next = state_reg; c1_next = c1_reg; code_next = code_reg; acc_next = acc_reg;
    neg_next = neg_reg; num_next = num_reg; qry_next = qry_reg; fld_next = fld_reg;
    eq_next = eq_reg; err_next = err_reg; bprog_next = bprog_reg; idx_next = idx_reg;
    fcnt_next = fcnt_reg; lmask_next = lmask_reg; bsize_next = bsize_reg; bplane_next = bplane_reg;
    bmask_next = bmask_reg; bpend_next = bpend_reg; lplane_next = lplane_reg; lcnt_next = lcnt_reg;
    hcnt_next = hcnt_reg; facc_next = facc_reg;
    resp_valid_next = 1'b0; cmd_valid_next = 1'b0; arg_valid_next = 1'b0;
    resp_data_next = resp_data_reg; cmd_binary_next = cmd_binary_reg; cmd_code_next = cmd_code_reg;
    cmask_next = cmask_reg; plane_s_next = plane_s_reg; plane_t_next = plane_t_reg;
    arg_axis_next = arg_axis_reg; arg_value_next = arg_value_reg; arg_frac_next = arg_frac_reg;
    rd_en = 1'b0; rd_addr = idx_reg;
    if (rx_valid) begin
      case (state_reg)
        ST_IDLE: begin
          acc_next = 32'h0; neg_next = 1'b0; num_next = 1'b0; qry_next = 1'b0; fld_next = 1'b0;
          eq_next = 1'b0; err_next = 1'b0; idx_next = 3'd0; lmask_next = 8'h00; lplane_next = 2'b00;
          lcnt_next = 2'd0;
          if (b >= CODE_MIN) begin // RL8
            code_next = b; hcnt_next = 2'd1; bprog_next = rx_from_program; state_next = ST_BHDR;
          end else if (upper) begin // RL1
            c1_next = b; state_next = ST_LET2;
          end else if (!isterm) begin
            state_next = ST_ERR; // RL17
          end
        end
        ST_LET2: begin
          if (upper) begin
            code_next = b; state_next = ST_ARGS; // RL1
          end else if (isterm) begin
            term = 1'b1; err_next = 1'b1;
          end else begin
            state_next = ST_ERR;
          end
        end
        ST_ARGS: begin
          if (isterm) begin
            fin = 1'b1; term = 1'b1;
          end else if (b == CH_SPACE) begin
            state_next = ST_ARGS;
          end else if (!fld_reg && !eq_reg && (axl || b == CH_S || b == CH_T)) begin
            if (axl) begin // RL6
              lmask_next = lmask_reg | 8'(8'h01 << dsub[2:0] - CH_A[2:0] + CH_0[2:0]);
              idx_next = 3'(b - CH_A);
            end else begin
              lplane_next = lplane_reg | ((b == CH_S) ? 2'b01 : 2'b10); // RL7
            end
            lcnt_next = (lcnt_reg == 2'd2) ? 2'd2 : lcnt_reg + 2'd1;
          end else if (b == CH_EQ && lcnt_reg == 2'd1 && lplane_reg == 2'b00 && !fld_reg && !eq_reg) begin
            eq_next = 1'b1; // RL5
          end else if (digit && !qry_reg && (lcnt_reg == 2'd0 || eq_reg)) begin
            acc_next = acc_reg * 32'd10 + {28'h0, dsub[3:0]}; num_next = 1'b1; fld_next = 1'b1;
          end else if (b == CH_MINUS && !num_reg && !qry_reg && (lcnt_reg == 2'd0 || eq_reg)) begin
            neg_next = 1'b1; fld_next = 1'b1;
          end else if (b == CH_QUERY && !num_reg && (lcnt_reg == 2'd0 || eq_reg)) begin
            qry_next = 1'b1; fld_next = 1'b1; // RL4
          end else if (b == CH_COMMA && !eq_reg && lcnt_reg == 2'd0 && idx_reg != AXIS_MAX) begin
            fin = 1'b1; fld_next = 1'b1; // RL3
          end else begin
            state_next = ST_ERR;
          end
        end
        ST_ERR: begin
          if (isterm) begin
            term = 1'b1; err_next = 1'b1; // RL2
          end
        end
        ST_BHDR: begin // RL10
          hcnt_next = hcnt_reg + 2'd1;
          if (hcnt_reg == 2'd1) bsize_next = b; // RL11
          if (hcnt_reg == 2'd2) bplane_next = b; // RL13
          if (hcnt_reg == HDR_LAST) begin
            bmask_next = b; bpend_next = b; bmk = b; fcnt_next = 3'd0; facc_next = 48'h0;
            bad = mcp_code_reserved(code_reg) || bprog_reg || (bplane_reg > PLANE_S); // RL9 RL16 RL18
            err_next = bad;
            if (!mcp_size_ok(bsize_reg) || bsize_reg == SIZE_NONE || b == 8'h00) begin
              err_next = bad || !mcp_size_ok(bsize_reg); // RL18
              bend = 1'b1;
            end else begin
              state_next = ST_BFLD;
            end
          end
        end
        ST_BFLD: begin
          facc_next = {facc_reg[39:0], b}; // RL15
          fcnt_next = fcnt_reg + 3'd1;
          if ({5'h00, fcnt_reg} + 8'h01 == bsize_reg) begin
            fcnt_next = 3'd0;
            arg_valid_next = !err_reg; arg_axis_next = ax; arg_frac_next = 16'h0; // RL14
            case (bsize_reg)
              SIZE_BYTE: arg_value_next = {{24{b[7]}}, b};
              SIZE_WORD: arg_value_next = {{16{facc_reg[7]}}, facc_reg[7:0], b};
              SIZE_LONG: arg_value_next = {facc_reg[23:0], b};
              default: begin
                arg_value_next = facc_reg[39:8]; arg_frac_next = {facc_reg[7:0], b}; // RL12
              end
            endcase
            bpend_next = bpend_reg & ~(8'(8'h01 << ax)); // RL15
            if ((bpend_reg & ~(8'(8'h01 << ax))) == 8'h00) bend = 1'b1;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
    if (fin) begin
      if (qry_reg) begin
        rd_en = 1'b1; // RL4
      end else if (num_reg) begin
        arg_valid_next = 1'b1; arg_axis_next = idx_reg; arg_frac_next = 16'h0;
        arg_value_next = neg_reg ? 32'h0 - acc_reg : acc_reg;
      end
      acc_next = 32'h0; neg_next = 1'b0; num_next = 1'b0; qry_next = 1'b0;
      if (!eq_reg && !term) idx_next = idx_reg + 3'd1;
    end
    if (term) begin
      resp_valid_next = 1'b1; state_next = ST_IDLE;
      resp_data_next = (state_reg == ST_ARGS) ? CH_COLON : CH_QUERY; // RL17
      if (state_reg == ST_ARGS) begin
        cmd_valid_next = 1'b1; cmd_binary_next = 1'b0; cmd_code_next = {c1_reg, code_reg}; // RL2
        cmask_next = (lmask_reg == 8'h00 && lplane_reg == 2'b00) ? AXIS_ALL : lmask_reg; // RL6
        plane_s_next = lplane_reg[0]; plane_t_next = lplane_reg[1];
      end
    end
    if (bend) begin
      resp_valid_next = 1'b1; state_next = ST_IDLE;
      resp_data_next = err_next ? CH_QUERY : CH_COLON; // RL17
      if (!err_next) begin
        cmd_valid_next = 1'b1; cmd_binary_next = 1'b1; cmd_code_next = {8'h00, code_reg}; // RL16
        cmask_next = bmk; plane_s_next = (bplane_reg == PLANE_S); plane_t_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE; c1_reg <= 8'h00; code_reg <= 8'h00; acc_reg <= 32'h0;
      neg_reg <= 1'b0; num_reg <= 1'b0; qry_reg <= 1'b0; fld_reg <= 1'b0; eq_reg <= 1'b0;
      err_reg <= 1'b0; bprog_reg <= 1'b0; idx_reg <= 3'd0; fcnt_reg <= 3'd0; lmask_reg <= 8'h00;
      bsize_reg <= 8'h00; bplane_reg <= 8'h00; bmask_reg <= 8'h00; bpend_reg <= 8'h00;
      lplane_reg <= 2'b00; lcnt_reg <= 2'd0; hcnt_reg <= 2'd0; facc_reg <= 48'h0;
      resp_valid_reg <= 1'b0; resp_data_reg <= 8'h00; cmd_valid_reg <= 1'b0; cmd_binary_reg <= 1'b0;
      cmd_code_reg <= 16'h0; cmask_reg <= 8'h00; plane_s_reg <= 1'b0; plane_t_reg <= 1'b0;
      arg_valid_reg <= 1'b0; arg_axis_reg <= 3'd0; arg_value_reg <= 32'h0; arg_frac_reg <= 16'h0;
    end else begin
      state_reg <= state_next; c1_reg <= c1_next; code_reg <= code_next; acc_reg <= acc_next;
      neg_reg <= neg_next; num_reg <= num_next; qry_reg <= qry_next; fld_reg <= fld_next; eq_reg <= eq_next;
      err_reg <= err_next; bprog_reg <= bprog_next; idx_reg <= idx_next; fcnt_reg <= fcnt_next;
      lmask_reg <= lmask_next; bsize_reg <= bsize_next; bplane_reg <= bplane_next; bmask_reg <= bmask_next;
      bpend_reg <= bpend_next; lplane_reg <= lplane_next; lcnt_reg <= lcnt_next; hcnt_reg <= hcnt_next;
      facc_reg <= facc_next; resp_valid_reg <= resp_valid_next; resp_data_reg <= resp_data_next;
      cmd_valid_reg <= cmd_valid_next; cmd_binary_reg <= cmd_binary_next; cmd_code_reg <= cmd_code_next;
      cmask_reg <= cmask_next; plane_s_reg <= plane_s_next; plane_t_reg <= plane_t_next;
      arg_valid_reg <= arg_valid_next; arg_axis_reg <= arg_axis_next; arg_value_reg <= arg_value_next;
      arg_frac_reg <= arg_frac_next;
    end
  end

  // stored per-axis values, written by every text argument value and by binary fields whose header was not rejected, read by queries
  mcp_axis_store u_store (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .wr_en    (arg_valid_next),
    .wr_addr  (arg_axis_next),
    .wr_data  (arg_value_next),
    .rd_en    (rd_en),
    .rd_addr  (rd_addr),
    .rd_valid (rpt_valid),
    .rd_axis  (rpt_axis),
    .rd_data  (rpt_value)
  );

  assign resp_valid    = resp_valid_reg;
  assign resp_data     = resp_data_reg;
  assign cmd_valid     = cmd_valid_reg;
  assign cmd_binary    = cmd_binary_reg;
  assign cmd_code      = cmd_code_reg;
  assign cmd_axis_mask = cmask_reg;
  assign cmd_plane_s   = plane_s_reg;
  assign cmd_plane_t   = plane_t_reg;
  assign arg_valid     = arg_valid_reg;
  assign arg_axis      = arg_axis_reg;
  assign arg_value     = arg_value_reg;
  assign arg_frac      = arg_frac_reg;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_text_term;
    rx_valid && state_reg == ST_ARGS && (rx_data == CH_SEMI || rx_data == CH_CR);
  endsequence
  sequence s_text_done;
    resp_valid && resp_data == CH_COLON && cmd_valid && !cmd_binary;
  endsequence
  property p_text_release;
    s_text_term |=> s_text_done;
  endproperty
  a_text_release: assert property (p_text_release) else $error("text command not released at terminator"); // RL2
  property p_lower_rejected;
    rx_valid && state_reg == ST_IDLE && rx_data >= 8'h61 && rx_data <= 8'h7A |=> state_reg == ST_ERR;
  endproperty
  a_lower_rejected: assert property (p_lower_rejected) else $error("lower case accepted"); // RL1
  property p_reply_matches;
    resp_valid |-> (resp_data == CH_COLON) == cmd_valid;
  endproperty
  a_reply_matches: assert property (p_reply_matches) else $error("reply does not match command validity"); // RL17
  property p_binary_start;
    rx_valid && state_reg == ST_IDLE && rx_data[7] |=> state_reg == ST_BHDR && code_reg == $past(rx_data);
  endproperty
  a_binary_start: assert property (p_binary_start) else $error("binary code not recognised"); // RL8
  property p_binary_legal;
    cmd_valid && cmd_binary |-> !mcp_code_reserved(cmd_code[7:0]) && mcp_size_ok(bsize_reg) && !bprog_reg;
  endproperty
  a_binary_legal: assert property (p_binary_legal) else $error("illegal binary command released"); // RL18
  property p_action_all;
    s_text_term ##0 (lmask_reg == 8'h00 && lplane_reg == 2'b00) |=> cmd_axis_mask == AXIS_ALL;
  endproperty
  a_action_all: assert property (p_action_all) else $error("empty axis list not all axes"); // RL6
  property p_empty_keeps;
    rx_valid && state_reg == ST_ARGS && rx_data == CH_COMMA && !num_reg |=> !arg_valid;
  endproperty
  a_empty_keeps: assert property (p_empty_keeps) else $error("empty position wrote a value"); // RL3
  property p_query_report;
    rx_valid && state_reg == ST_ARGS && qry_reg && (rx_data == CH_COMMA || rx_data == CH_SEMI)
      |=> rpt_valid && rpt_axis == $past(idx_reg) && !arg_valid;
  endproperty
  a_query_report: assert property (p_query_report) else $error("query did not report stored value"); // RL4
  property p_field_order;
    rx_valid && state_reg == ST_BFLD && !err_reg && {5'h00, fcnt_reg} + 8'h01 == bsize_reg
      |=> arg_valid && arg_axis == mcp_lowest_bit($past(bpend_reg));
  endproperty
  a_field_order: assert property (p_field_order) else $error("binary field axis out of order"); // RL15
  property p_assign_axis;
    rx_valid && state_reg == ST_ARGS && eq_reg && num_reg && (rx_data == CH_SEMI || rx_data == CH_CR)
      |=> arg_valid && arg_axis == $past(idx_reg) ##1 resp_valid == 1'b0;
  endproperty
  a_assign_axis: assert property (p_assign_axis) else $error("assignment went to wrong axis"); // RL5
endmodule : mcp_parser

// ===== mcp_pkg.sv
// constants, states and decode helpers for the motion command parser
package mcp_pkg;

  // ascii characters of the text syntax
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_EQ    = 8'h3D;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_H     = 8'h48;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_Z     = 8'h5A;

  // binary header
  localparam logic [7:0] CODE_MIN                    = 8'h80;
  localparam logic [7:0] CODE_BEGIN_MOTION           = 8'hA0;
  localparam logic [7:0] CODE_HALT_MOTION            = 8'hA1;
  localparam logic [7:0] CODE_HOMING_SEQUENCE        = 8'hA3;
  localparam logic [7:0] CODE_RELATIVE_POSITION_MOVE = 8'hA7;
  localparam logic [7:0] SIZE_NONE  = 8'h00;
  localparam logic [7:0] SIZE_BYTE  = 8'h01;
  localparam logic [7:0] SIZE_WORD  = 8'h02;
  localparam logic [7:0] SIZE_LONG  = 8'h04;
  localparam logic [7:0] SIZE_REAL  = 8'h06;
  localparam logic [7:0] PLANE_NONE = 8'h00;
  localparam logic [7:0] PLANE_S    = 8'h01;
  localparam logic [1:0] HDR_LAST   = 2'd3;

  // axes
  localparam int         NUM_AXES = 8;
  localparam logic [7:0] AXIS_ALL = 8'hFF;
  localparam logic [2:0] AXIS_MAX = 3'd7;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_LET2 = 6'b000010,
    ST_ARGS = 6'b000100,
    ST_ERR  = 6'b001000,
    ST_BHDR = 6'b010000,
    ST_BFLD = 6'b100000
  } mcp_state_type;

  // codes with no command, and anything below the binary range
  function automatic logic mcp_code_reserved(input logic [7:0] c);
    return (c < CODE_MIN) || (c == 8'h80) || (c == 8'h85) || (c >= 8'h9B && c <= 8'h9F) ||
           (c >= 8'hAB && c <= 8'hAF) || (c == 8'hB3) || (c == 8'hBB) || (c == 8'hBC) ||
           (c == 8'hC7) || (c >= 8'hD5 && c <= 8'hD7) || (c >= 8'hE2 && c <= 8'hE4) || (c >= 8'hEF);
  endfunction : mcp_code_reserved

  function automatic logic mcp_size_ok(input logic [7:0] s);
    return (s == SIZE_NONE) || (s == SIZE_BYTE) || (s == SIZE_WORD) || (s == SIZE_LONG) || (s == SIZE_REAL);
  endfunction : mcp_size_ok

  function automatic logic [2:0] mcp_lowest_bit(input logic [7:0] m);
    logic [2:0] r;
    r = 3'd0;
    for (int i = NUM_AXES - 1; i >= 0; i--) begin
      if (m[i]) r = 3'(i);
    end
    return r;
  endfunction : mcp_lowest_bit

endpackage : mcp_pkg

// ===== motion_command_parser_bench.sv
// self-checking bench for the motion command parser
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin logic [63:0] chk_v; chk_v = 64'(got); num_checks++; \
  if (chk_v !== 64'(ex)) begin fail_count++; $display("[ERR] %s expected %h seen %h", nm, ex, chk_v); end end
module motion_command_parser_bench;
  import mcp_pkg::*;
  logic mclk, arst_n, rx_valid, rx_from_program, resp_valid, cmd_valid, cmd_binary;
  logic cmd_plane_s, cmd_plane_t, arg_valid, rpt_valid;
  logic [7:0] rx_data, resp_data, cmd_axis_mask;
  logic [15:0] cmd_code, arg_frac;
  logic [2:0] arg_axis, rpt_axis;
  logic [31:0] arg_value, rpt_value;
  logic [7:0] resp_q[$];
  logic [50:0] arg_q[$];
  logic [34:0] rpt_q[$];
  logic [26:0] cmd_q[$];
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  mcp_host_model host (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data));
  mcp_parser DUT (.mclk(mclk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_from_program(rx_from_program), .resp_valid(resp_valid), .resp_data(resp_data),
    .cmd_valid(cmd_valid), .cmd_binary(cmd_binary), .cmd_code(cmd_code), .cmd_axis_mask(cmd_axis_mask),
    .cmd_plane_s(cmd_plane_s), .cmd_plane_t(cmd_plane_t), .arg_valid(arg_valid), .arg_axis(arg_axis),
    .arg_value(arg_value), .arg_frac(arg_frac), .rpt_valid(rpt_valid), .rpt_axis(rpt_axis),
    .rpt_value(rpt_value));
  // one-cycle pulses collected into queues
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
    if (resp_valid === 1'b1) resp_q.push_back(resp_data);
    if (arg_valid === 1'b1) arg_q.push_back({arg_axis, arg_value, arg_frac});
    if (rpt_valid === 1'b1) rpt_q.push_back({rpt_axis, rpt_value});
    if (cmd_valid === 1'b1) cmd_q.push_back({cmd_binary, cmd_plane_s, cmd_plane_t, cmd_code, cmd_axis_mask});
  end
  task automatic flush();
    resp_q.delete();
    arg_q.delete();
    rpt_q.delete();
    cmd_q.delete();
  endtask : flush
  task automatic run();
    int n;
    n = 0;
    @(negedge mclk);
    while ((host.byte_q.size() != 0 || resp_q.size() == 0) && n < 80) begin
      @(negedge mclk);
      n++;
    end
    repeat (3) @(negedge mclk);
  endtask : run
  task automatic bin(input logic [7:0] b[$], input logic prog, input logic [7:0] rsp);
    flush();
    rx_from_program = prog;
    host.put(b);
    run();
    `CHK("reply", rsp, resp_q.pop_front())
  endtask : bin
  task automatic t_text();
    flush();
    host.text("PR 5;PR,-7;");
    run();
    `CHK("arg", {3'd0, 32'h0000_0005, 16'h0000}, arg_q.pop_front())
    `CHK("arg", {3'd1, 32'hFFFF_FFF9, 16'h0000}, arg_q.pop_front())
    `CHK("cmd", {3'b000, 16'h5052, 8'hFF}, cmd_q.pop_front())
    `CHK("reply", CH_COLON, resp_q.pop_front())
    flush();
    host.text("PR ?,?;PRC=9\r");
    run();
    `CHK("rpt", {3'd0, 32'h0000_0005}, rpt_q.pop_front())
    `CHK("rpt", {3'd1, 32'hFFFF_FFF9}, rpt_q.pop_front())
    `CHK("arg", {3'd2, 32'h0000_0009, 16'h0000}, arg_q.pop_front())
    `CHK("args", 0, arg_q.size())
  endtask : t_text
  task automatic t_action();
    flush();
    host.text("BG TD;BG;bg;");
    run();
    `CHK("cmd", {3'b001, 16'h4247, 8'h08}, cmd_q.pop_front())
    `CHK("cmd", {3'b000, 16'h4247, 8'hFF}, cmd_q.pop_front())
    `CHK("cmds", 0, cmd_q.size())
    `CHK("reply", CH_COLON, resp_q.pop_front())
    `CHK("reply", CH_COLON, resp_q.pop_front())
    `CHK("reply", CH_QUERY, resp_q.pop_front())
  endtask : t_action
  task automatic t_binary();
    bin('{8'hA7, 8'h02, 8'h00, 8'h05, 8'h03, 8'hE8, 8'hFE, 8'h0C}, 1'b0, CH_COLON);
    `CHK("arg", {3'd0, 32'd1000, 16'h0000}, arg_q.pop_front())
    `CHK("arg", {3'd2, 32'hFFFF_FE0C, 16'h0000}, arg_q.pop_front())
    `CHK("cmd", {3'b100, 16'h00A7, 8'h05}, cmd_q.pop_front())
    bin('{8'hA7, 8'h06, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h03, 8'h80, 8'h00}, 1'b0, CH_COLON);
    `CHK("arg", {3'd1, 32'd3, 16'h8000}, arg_q.pop_front())
    `CHK("cmd", {3'b110, 16'h00A7, 8'h02}, cmd_q.pop_front())
    bin('{8'hA7, 8'h01, 8'h00, 8'h80, 8'hFF}, 1'b0, CH_COLON);
    `CHK("arg", {3'd7, 32'hFFFF_FFFF, 16'h0000}, arg_q.pop_front())
    bin('{8'hA7, 8'h04, 8'h00, 8'h08, 8'h00, 8'h01, 8'h00, 8'h10}, 1'b0, CH_COLON);
    `CHK("arg", {3'd3, 32'h0001_0010, 16'h0000}, arg_q.pop_front())
    bin('{8'hA1, 8'h00, 8'h01, 8'h07}, 1'b0, CH_COLON);
    `CHK("cmd", {3'b110, 16'h00A1, 8'h07}, cmd_q.pop_front())
    bin('{8'hA0, 8'h00, 8'h00, 8'h01}, 1'b1, CH_QUERY);
    `CHK("cmds", 0, cmd_q.size())
    bin('{8'h80, 8'h00, 8'h00, 8'h00}, 1'b0, CH_QUERY);
    bin('{8'h7F, 8'h00, 8'h00, 8'h00, 8'h3B}, 1'b0, CH_QUERY);
    bin('{8'hA0, 8'h03, 8'h00, 8'h00}, 1'b0, CH_QUERY);
    bin('{8'hA0, 8'h00, 8'h02, 8'h00}, 1'b0, CH_QUERY);
    bin('{8'hA3, 8'h00, 8'h00, 8'h01}, 1'b0, CH_COLON);
  endtask : t_binary
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    arst_n = 1'b0;
    rx_from_program = 1'b0;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    @(negedge mclk);
    t_text();
    t_action();
    t_binary();
    print_verdict();
  end
endmodule : motion_command_parser_bench
